// ---- core/eeprom_host.sv ----
`timescale 1ns/1ps
`include "eeprom_host_params.svh"
// Operation
// - write starts with low strobe pulse, gate high, select low
// - without completion pin the host detects end by polling
// - host starts no access until write end detected or the write timeout expires
// - clear: select low, gate high-voltage, 10 ms strobe pulse
// - id line high-voltage maps 1fe0..1fff to 32 id bytes
module eeprom_host #(
  parameter int POWERUP_CYC = `POWERUP_CYC,
  parameter int CLEAR_CYC = `CLEAR_PULSE_CYC,
  parameter int TIMEOUT_CYC = `WRITE_CYCLE_CYC,
  parameter bit USE_READY_PIN = 1'b1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic reqValid,
  input wire eeprom_host_pkg::req_t req,
  output logic reqReady,
  output logic doneValid,
  output logic [7:0] doneData,
  output logic doneTimeout,
  output logic [12:0] addrLines,
  output eeprom_host_pkg::strobes_t strobes,
  input wire logic [7:0] dataLinesIn,
  output logic [7:0] dataLinesOut,
  output logic dataLinesOe,
  input wire logic readyPin
);
  typedef enum logic [2:0] {
    ST_POWERUP, ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD, ST_READ, ST_POLL, ST_POLLGAP
  } state_t;
  localparam int CNT_W = 24;
  // ==========================================
  // ready pin synchroniser, three stages
  logic [2:0] rdySync;
  logic rdyLevel;
  logic [2:0] next_rdySync;
  logic next_rdyLevel;
  always_comb begin
    next_rdySync = {rdySync[1:0], readyPin};
    next_rdyLevel = rdyLevel;
    if (rdySync[2] == rdySync[1]) begin
      next_rdyLevel = rdySync[2];
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdySync <= 3'h7;
      rdyLevel <= 1'b1;
    end else begin
      rdySync <= next_rdySync;
      rdyLevel <= next_rdyLevel;
    end
  end
  // ==========================================
  // sequencer
  state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt, waitCnt, next_waitCnt;
  eeprom_host_pkg::req_t cur, next_cur;
  logic next_reqReady, next_doneValid, next_doneTimeout, next_dataLinesOe;
  logic [7:0] next_doneData, next_dataLinesOut;
  logic [12:0] next_addrLines;
  eeprom_host_pkg::strobes_t next_strobes;
  logic pollHit;
  assign pollHit = (dataLinesIn[`POLL_BIT] == cur.data[`POLL_BIT]);
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_waitCnt = waitCnt;
    next_cur = cur;
    next_reqReady = 1'b0;
    next_doneValid = 1'b0;
    next_doneData = doneData;
    next_doneTimeout = 1'b0;
    next_addrLines = addrLines;
    next_strobes = strobes;
    next_dataLinesOut = dataLinesOut;
    next_dataLinesOe = dataLinesOe;
    case (state)
      ST_POWERUP: begin
        next_cnt = cnt + 1'b1;
        if (cnt >= CNT_W'(POWERUP_CYC)) begin
          next_state = ST_IDLE;
          next_reqReady = 1'b1;
        end
      end
      ST_IDLE: begin
        next_reqReady = 1'b1;
        if (reqValid && reqReady) begin
          next_reqReady = 1'b0;
          next_cur = req;
          next_addrLines = req.addr;
          next_strobes.idSpaceHv = req.idSpace;
          next_strobes.chipSelN = 1'b0;
          next_strobes.outGateN = 1'b1;
          next_strobes.outGateHv = (req.op == eeprom_host_pkg::CMD_CLEAR);
          next_dataLinesOut = req.data;
          next_dataLinesOe = (req.op == eeprom_host_pkg::CMD_WRITE);
          next_cnt = '0;
          next_state = (req.op == eeprom_host_pkg::CMD_READ) ? ST_READ : ST_SETUP;
          if (req.op == eeprom_host_pkg::CMD_READ) begin
            next_strobes.outGateN = 1'b0;
          end
        end
      end
      ST_SETUP: begin
        next_cnt = cnt + 1'b1;
        if (cnt >= CNT_W'(`SETUP_CYC - 1)) begin
          next_strobes.writeStrobeN = 1'b0;
          next_cnt = '0;
          next_state = ST_PULSE;
        end
      end
      ST_PULSE: begin
        next_cnt = cnt + 1'b1;
        if (cnt >= ((cur.op == eeprom_host_pkg::CMD_CLEAR) ? CNT_W'(CLEAR_CYC - 1) : CNT_W'(`WRITE_PULSE_CYC - 1))) begin
          next_strobes.writeStrobeN = 1'b1;
          next_cnt = '0;
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        next_cnt = cnt + 1'b1;
        if (cnt >= CNT_W'(`SETUP_CYC - 1)) begin
          next_dataLinesOe = 1'b0;
          next_strobes.outGateHv = 1'b0;
          next_strobes.chipSelN = 1'b1;
          next_cnt = '0;
          next_waitCnt = '0;
          next_state = (cur.op == eeprom_host_pkg::CMD_CLEAR) ? ST_IDLE : ST_POLLGAP;
          next_doneValid = (cur.op == eeprom_host_pkg::CMD_CLEAR);
          next_reqReady = (cur.op == eeprom_host_pkg::CMD_CLEAR);
        end
      end
      ST_READ: begin
        next_cnt = cnt + 1'b1;
        if (cnt >= CNT_W'(`READ_ACCESS_CYC)) begin
          next_doneData = dataLinesIn;
          next_doneValid = 1'b1;
          next_strobes.chipSelN = 1'b1;
          next_strobes.outGateN = 1'b1;
          next_strobes.idSpaceHv = 1'b0;
          next_reqReady = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_POLLGAP: begin
        // wait for pin release, or poll when the pin is absent
        next_waitCnt = waitCnt + 1'b1;
        next_cnt = cnt + 1'b1;
        if (USE_READY_PIN && rdyLevel && cnt >= CNT_W'(`SETUP_CYC)) begin
          next_doneValid = 1'b1;
          next_doneData = cur.data;
          next_strobes.idSpaceHv = 1'b0;
          next_reqReady = 1'b1;
          next_state = ST_IDLE;
        end else if (!USE_READY_PIN && cnt >= CNT_W'(`SETUP_CYC)) begin
          next_strobes.chipSelN = 1'b0;
          next_strobes.outGateN = 1'b0;
          next_cnt = '0;
          next_state = ST_POLL;
        end else if (waitCnt >= CNT_W'(TIMEOUT_CYC)) begin
          next_doneValid = 1'b1;
          next_doneTimeout = 1'b1;
          next_strobes.idSpaceHv = 1'b0;
          next_reqReady = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_POLL: begin
        next_waitCnt = waitCnt + 1'b1;
        next_cnt = cnt + 1'b1;
        if (cnt >= CNT_W'(`READ_ACCESS_CYC)) begin
          next_strobes.chipSelN = 1'b1;
          next_strobes.outGateN = 1'b1;
          next_cnt = '0;
          if (pollHit) begin
            next_doneValid = 1'b1;
            next_doneData = dataLinesIn;
            next_strobes.idSpaceHv = 1'b0;
            next_reqReady = 1'b1;
            next_state = ST_IDLE;
          end else begin
            next_state = ST_POLLGAP;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_POWERUP;
      cnt <= '0;
      waitCnt <= '0;
      cur <= '0;
      reqReady <= 1'b0;
      doneValid <= 1'b0;
      doneData <= 8'h00;
      doneTimeout <= 1'b0;
      addrLines <= 13'h0000;
      strobes <= 5'h1c;
      dataLinesOut <= 8'h00;
      dataLinesOe <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      waitCnt <= next_waitCnt;
      cur <= next_cur;
      reqReady <= next_reqReady;
      doneValid <= next_doneValid;
      doneData <= next_doneData;
      doneTimeout <= next_doneTimeout;
      addrLines <= next_addrLines;
      strobes <= next_strobes;
      dataLinesOut <= next_dataLinesOut;
      dataLinesOe <= next_dataLinesOe;
    end
  end
  // ==========================================
  // checks
  chk_pulse_gate: assert property (@(posedge mclk) disable iff (!rst_n)
    !strobes.writeStrobeN |-> (strobes.outGateN && !strobes.chipSelN)) else $error("strobe low without gate high");
  chk_no_drive_read: assert property (@(posedge mclk) disable iff (!rst_n)
    !strobes.outGateN |-> !dataLinesOe) else $error("host drives during read");
  chk_data_stable: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(strobes.writeStrobeN) |-> $stable(dataLinesOut) && $stable(addrLines)) else $error("data moved at latch");
  chk_no_req_busy: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == ST_POLLGAP || state == ST_POLL) |-> !reqReady) else $error("ready during write");
  chk_powerup_wait: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == ST_POWERUP) |-> !reqReady && strobes.writeStrobeN) else $error("access before powerup");
  chk_clear_hv: assert property (@(posedge mclk) disable iff (!rst_n)
    (!strobes.writeStrobeN && cur.op == eeprom_host_pkg::CMD_CLEAR) |-> strobes.outGateHv) else $error("clear w/o hv");
  chk_done_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
    doneValid |=> !doneValid) else $error("done longer than a cycle");
  chk_hv_off_read: assert property (@(posedge mclk) disable iff (!rst_n)
    !strobes.outGateN |-> !strobes.outGateHv && strobes.writeStrobeN) else $error("bad read strobes");
  cov_write: cover property (@(posedge mclk) disable iff (!rst_n) state == ST_HOLD ##1 state == ST_POLLGAP);
  cov_read: cover property (@(posedge mclk) disable iff (!rst_n) state == ST_READ ##1 state == ST_IDLE);
  cov_timeout: cover property (@(posedge mclk) disable iff (!rst_n) doneTimeout);
  cov_poll_hit: cover property (@(posedge mclk) disable iff (!rst_n) state == ST_POLL ##1 (state == ST_IDLE && doneValid));
endmodule // eeprom_host

// ---- core/eeprom_host_params.svh ----
`ifndef EEPROM_HOST_PARAMS_SVH
`define EEPROM_HOST_PARAMS_SVH
// ==========================================
// timing and layout constants
`define CLK_PERIOD_NS 40
`define ADDR_WIDTH 13
`define DATA_WIDTH 8
`define POLL_BIT 7
`define ID_FIRST 13'h1fe0
`define ID_LAST 13'h1fff
`define WRITE_PULSE_NS 200
`define WRITE_PULSE_CYC ((`WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_ACCESS_NS 250
`define READ_ACCESS_CYC ((`READ_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_NS 80
`define SETUP_CYC ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CLEAR_PULSE_MS 10
`define CLEAR_PULSE_CYC ((`CLEAR_PULSE_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POWERUP_MS 5
`define POWERUP_CYC ((`POWERUP_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_CYCLE_MS 1
`define WRITE_CYCLE_CYC ((`WRITE_CYCLE_MS * 1000000) / `CLK_PERIOD_NS)
`endif

// ---- core/eeprom_host_pkg.sv ----
package eeprom_host_pkg;
  // ==========================================
  // command and pin types
  typedef enum logic [1:0] {
    CMD_READ,
    CMD_WRITE,
    CMD_CLEAR
  } cmd_t;
  typedef struct packed {
    cmd_t op;
    logic idSpace;
    logic [12:0] addr;
    logic [7:0] data;
  } req_t;
  typedef struct packed {
    logic chipSelN;
    logic outGateN;
    logic writeStrobeN;
    logic outGateHv;
    logic idSpaceHv;
  } strobes_t;
endpackage

// ---- tb/eeprom_dev_model.sv ----
`timescale 1ns/1ps
// ==========================================
// behavioural byte-wide memory on the far side
module eeprom_dev_model (
  input wire logic [12:0] addrLines,
  input wire eeprom_host_pkg::strobes_t strobes,
  input wire logic [7:0] dataLinesOut,
  input wire logic dataLinesOe,
  output logic [7:0] dataLinesIn,
  output logic readyPin
);
  int wcNs = 2000;
  logic [7:0] mem [0:8191];
  logic [7:0] idMem [0:31];
  logic busy = 1'b0;
  logic supplyOk = 1'b1; // supply sense, lowered by the bench
  logic armed = 1'b0;
  logic idWr = 1'b0;
  logic drv;
  logic [12:0] wAddr = 13'h0000;
  logic [7:0] wData = 8'h00;
  logic [7:0] val;
  logic [7:0] last = 8'h00;
  // strobe fall: qualify the write and latch the address
  always @(negedge strobes.writeStrobeN) begin
    armed = supplyOk && !busy && !strobes.chipSelN && strobes.outGateN && $time > 400;
    wAddr = addrLines;
    idWr = strobes.idSpaceHv;
  end
  // strobe rise: clear erases at once; a write latches data, then runs a self-timed program
  always @(posedge strobes.writeStrobeN) begin
    if (armed && strobes.outGateHv) begin
      foreach (mem[i]) mem[i] = 8'hff;
    end else if (armed) begin
      wData = dataLinesOut;
      busy = 1'b1;
      #(wcNs);
      if (idWr && wAddr >= 13'h1fe0) idMem[wAddr[4:0]] = wData;
      else mem[wAddr] = wData;
      busy = 1'b0;
    end
    armed = 1'b0;
  end
  // read path: poll byte while busy, array byte otherwise
  always @* begin
    drv = !strobes.chipSelN && !strobes.outGateN && strobes.writeStrobeN;
    if (busy) val = {~wData[7], wAddr[6:0]};
    else if (strobes.idSpaceHv && addrLines >= 13'h1fe0) val = idMem[addrLines[4:0]];
    else val = mem[addrLines];
  end
  // remember the last driven byte so a released bus shows its inverse
  always @(val or drv) if (drv) last = val;
  assign dataLinesIn = dataLinesOe ? dataLinesOut : (drv ? val : ~last);
  assign readyPin = busy ? 1'b0 : 1'b1;
endmodule // eeprom_dev_model

// ---- tb/eeprom_host_tb.sv ----
`timescale 1ns/1ps
// ==========================================
// directed bench for the memory host controller
module eeprom_host_tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic reqValid = 1'b0;
  eeprom_host_pkg::req_t req = '0;
  logic reqReady, doneValid, doneTimeout, dataLinesOe, readyPin;
  logic [7:0] doneData, dataLinesOut, dataLinesIn;
  logic [12:0] addrLines;
  eeprom_host_pkg::strobes_t strobes;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int took = 0;
  logic pReqValid = 1'b0;
  eeprom_host_pkg::req_t pReq = '0;
  logic pReqReady, pDoneValid, pDoneTimeout, pOe, pReadyPin;
  logic [7:0] pDoneData, pOut, pIn;
  logic [12:0] pAddr;
  eeprom_host_pkg::strobes_t pStrobes;
  eeprom_host #(.POWERUP_CYC(20), .CLEAR_CYC(20), .TIMEOUT_CYC(200), .USE_READY_PIN(1'b1)) dut (
    .mclk(mclk), .rst_n(rst_n), .reqValid(reqValid), .req(req), .reqReady(reqReady),
    .doneValid(doneValid), .doneData(doneData), .doneTimeout(doneTimeout), .addrLines(addrLines),
    .strobes(strobes), .dataLinesIn(dataLinesIn), .dataLinesOut(dataLinesOut),
    .dataLinesOe(dataLinesOe), .readyPin(readyPin)
  );
  eeprom_dev_model dev (
    .addrLines(addrLines), .strobes(strobes), .dataLinesOut(dataLinesOut),
    .dataLinesOe(dataLinesOe), .dataLinesIn(dataLinesIn), .readyPin(readyPin)
  );
  // second host in polling mode, with its own memory
  eeprom_host #(.POWERUP_CYC(20), .CLEAR_CYC(20), .TIMEOUT_CYC(200), .USE_READY_PIN(1'b0)) dutPoll (
    .mclk(mclk), .rst_n(rst_n), .reqValid(pReqValid), .req(pReq), .reqReady(pReqReady),
    .doneValid(pDoneValid), .doneData(pDoneData), .doneTimeout(pDoneTimeout), .addrLines(pAddr),
    .strobes(pStrobes), .dataLinesIn(pIn), .dataLinesOut(pOut),
    .dataLinesOe(pOe), .readyPin(pReadyPin)
  );
  eeprom_dev_model devPoll (
    .addrLines(pAddr), .strobes(pStrobes), .dataLinesOut(pOut),
    .dataLinesOe(pOe), .dataLinesIn(pIn), .readyPin(pReadyPin)
  );
  // clock
  initial forever #20 mclk = ~mclk;
  // hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      test_done();
    end
  end
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one request, held until taken, then wait for its completion
  task automatic op(input eeprom_host_pkg::cmd_t c, input logic ids, input logic [12:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    #1;
    reqValid = 1'b1;
    req = '{c, ids, a, d};
    while (reqReady !== 1'b1 && n < 2000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    @(posedge mclk);
    #1;
    reqValid = 1'b0;
    took = 0;
    while (doneValid !== 1'b1 && took < 2000) begin
      @(posedge mclk);
      #1;
      took++;
    end
    if (n >= 2000 || took >= 2000) errors++;
  endtask
  // one request to the polling host, held until taken, then wait for completion
  task automatic pop(input eeprom_host_pkg::cmd_t c, input logic [12:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    #1;
    pReqValid = 1'b1;
    pReq = '{c, 1'b0, a, d};
    while (pReqReady !== 1'b1 && n < 2000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    @(posedge mclk);
    #1;
    pReqValid = 1'b0;
    took = 0;
    while (pDoneValid !== 1'b1 && took < 2000) begin
      @(posedge mclk);
      #1;
      took++;
    end
    if (n >= 2000 || took >= 2000) errors++;
  endtask
  task automatic t_poll();
    pop(eeprom_host_pkg::CMD_WRITE, 13'h0042, 8'h96);
    chk(pDoneTimeout, 1'b0);
    chk(pDoneData, 8'h96);
    chk(took >= 50, 1'b1);
    pop(eeprom_host_pkg::CMD_READ, 13'h0042, 8'h00);
    chk(pDoneData, 8'h96);
    $display("poll test done");
  endtask
  task automatic t_reset();
    @(posedge mclk);
    #1;
    chk(strobes, 5'b11100);
    chk(reqReady, 1'b0);
    @(posedge mclk);
    #1;
    rst_n = 1'b1;
    repeat (18) @(posedge mclk);
    #1;
    chk(reqReady, 1'b0);
    repeat (3) @(posedge mclk);
    #1;
    chk(reqReady, 1'b1);
    $display("reset test done");
  endtask
  task automatic t_write_read();
    op(eeprom_host_pkg::CMD_WRITE, 1'b0, 13'h0123, 8'h5a);
    chk(doneTimeout, 1'b0);
    chk(took >= 50, 1'b1);
    op(eeprom_host_pkg::CMD_READ, 1'b0, 13'h0123, 8'h00);
    chk(doneData, 8'h5a);
    @(posedge mclk);
    #1;
    chk({strobes, dataLinesOe}, 6'b111000);
    dev.supplyOk = 1'b0;
    op(eeprom_host_pkg::CMD_WRITE, 1'b0, 13'h0123, 8'h77);
    dev.supplyOk = 1'b1;
    op(eeprom_host_pkg::CMD_READ, 1'b0, 13'h0123, 8'h00);
    chk(doneData, 8'h5a);
    $display("write read test done");
  endtask
  task automatic t_bounds();
    logic [12:0] a [3] = '{13'h0000, 13'h1fff, 13'h0001};
    logic [7:0] d [3] = '{8'hff, 8'h00, 8'ha5};
    for (int i = 0; i < 3; i++) op(eeprom_host_pkg::CMD_WRITE, 1'b0, a[i], d[i]);
    for (int i = 0; i < 3; i++) begin
      op(eeprom_host_pkg::CMD_READ, 1'b0, a[i], 8'h00);
      chk(doneData, d[i]);
    end
    $display("address bounds test done");
  endtask
  task automatic t_id_space();
    op(eeprom_host_pkg::CMD_WRITE, 1'b1, 13'h1fe0, 8'h3c);
    op(eeprom_host_pkg::CMD_WRITE, 1'b0, 13'h1fe0, 8'hc3);
    op(eeprom_host_pkg::CMD_READ, 1'b1, 13'h1fe0, 8'h00);
    chk(doneData, 8'h3c);
    op(eeprom_host_pkg::CMD_READ, 1'b0, 13'h1fe0, 8'h00);
    chk(doneData, 8'hc3);
    $display("id space test done");
  endtask
  task automatic t_clear();
    op(eeprom_host_pkg::CMD_CLEAR, 1'b0, 13'h0000, 8'h00);
    op(eeprom_host_pkg::CMD_READ, 1'b0, 13'h0123, 8'h00);
    chk(doneData, 8'hff);
    op(eeprom_host_pkg::CMD_READ, 1'b0, 13'h1fff, 8'h00);
    chk(doneData, 8'hff);
    $display("clear test done");
  endtask
  task automatic t_timeout();
    int n;
    n = 0;
    dev.wcNs = 20000;
    op(eeprom_host_pkg::CMD_WRITE, 1'b0, 13'h0200, 8'h11);
    chk(doneTimeout, 1'b1);
    while (readyPin !== 1'b1 && n < 1000) begin
      @(posedge mclk);
      n++;
    end
    op(eeprom_host_pkg::CMD_READ, 1'b0, 13'h0200, 8'h00);
    chk(doneData, 8'h11);
    $display("timeout test done");
  endtask
  // main sequence
  initial begin
    t_reset();
    t_write_read();
    t_bounds();
    t_id_space();
    t_clear();
    t_poll();
    t_timeout();
    test_done();
  end
endmodule // eeprom_host_tb
